// [common/pls_pkg.sv]
// Shared constants and types for the protection latch sequencer
package pls_pkg;
    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 10;
    localparam int unsigned T_EXT65_US    = 55;
    localparam int unsigned T_EXT100_US   = 35;
    localparam int unsigned T_LHI_US      = 50;
    localparam int unsigned T_LLO_US      = 350;
    localparam int unsigned T_VCC_US      = 10;
    localparam int unsigned T_THERM_US    = 10;
    localparam int unsigned T_OFF_MS      = 150;
    localparam int unsigned T_SSTART_MS   = 10;
    localparam int unsigned T_FAULT_US    = 100;
    localparam int unsigned T_AUTOREC_MS  = 1;

    localparam int unsigned EXT65_CYC   = T_EXT65_US * CLK_MHZ;
    localparam int unsigned EXT100_CYC  = T_EXT100_US * CLK_MHZ;
    localparam int unsigned LHI_CYC     = T_LHI_US * CLK_MHZ;
    localparam int unsigned LLO_CYC     = T_LLO_US * CLK_MHZ;
    localparam int unsigned VCC_CYC     = T_VCC_US * CLK_MHZ;
    localparam int unsigned THERM_CYC   = T_THERM_US * CLK_MHZ;
    localparam int unsigned OFF_CYC     = T_OFF_MS * 1000 * CLK_MHZ;
    localparam int unsigned SSTART_CYC  = T_SSTART_MS * 1000 * CLK_MHZ;
    localparam int unsigned FAULT_CYC   = T_FAULT_US * CLK_MHZ;
    localparam int unsigned AUTOREC_CYC = T_AUTOREC_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // Qualifier channels
    // ------------------------------------------------------------------
    localparam int unsigned QW     = 21;
    localparam int unsigned NQ     = 10;
    localparam int unsigned Q_EXT  = 0;
    localparam int unsigned Q_LHI  = 1;
    localparam int unsigned Q_LLO  = 2;
    localparam int unsigned Q_VLO  = 3;
    localparam int unsigned Q_VHI  = 4;
    localparam int unsigned Q_THRM = 5;
    localparam int unsigned Q_OFFM = 6;
    localparam int unsigned Q_OVL  = 7;
    localparam int unsigned Q_SS   = 8;
    localparam int unsigned Q_AR   = 9;

    // ------------------------------------------------------------------
    // Event bits of the status and mask registers
    // ------------------------------------------------------------------
    localparam int unsigned NEV    = 10;
    localparam int unsigned EV_EXT = 0;
    localparam int unsigned EV_LHI = 1;
    localparam int unsigned EV_LLO = 2;
    localparam int unsigned EV_VLO = 3;
    localparam int unsigned EV_VHI = 4;
    localparam int unsigned EV_THM = 5;
    localparam int unsigned EV_OFF = 6;
    localparam int unsigned EV_OVL = 7;
    localparam int unsigned EV_SHT = 8;
    localparam int unsigned EV_BO  = 9;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and reset values
    // ------------------------------------------------------------------
    localparam int unsigned AW        = 4;
    localparam logic [3:0]  OFS_CTRL  = 4'h0;
    localparam logic [3:0]  OFS_STAT  = 4'h4;
    localparam logic [3:0]  OFS_MASK  = 4'h8;
    localparam logic [3:0]  OFS_STATE = 4'hC;
    localparam int unsigned CTRL_EN   = 0;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
    localparam logic [31:0] MASK_RST  = 32'h0000_0000;
    localparam int unsigned STATE_AUTO = 8;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_SSTART = 6'h02,
        ST_RUN    = 6'h04,
        ST_LATCH  = 6'h08,
        ST_THERM  = 6'h10,
        ST_SLEEP  = 6'h20
    } pls_state_e;
endpackage : pls_pkg

// [common/pls_qual_if.sv]
// Interface between the sequencer and its qualification timer bank
`timescale 1ns/10ps
interface pls_qual_if;
    import pls_pkg::*;
    logic [NQ-1:0] cond;
    logic [NQ-1:0] done;
    logic [QW-1:0] limit [NQ];

    modport bank (input cond, input limit, output done);
    modport user (output cond, output limit, input done);
endinterface : pls_qual_if

// [hdl/pls_qual_bank.sv]
// Bank of qualification timers, one per timed fault condition (not the CS_STOP short) and the off-mode delay, plus the soft-start and autorecovery delays
`timescale 1ns/10ps
module pls_qual_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Channels
    pls_qual_if.bank q
);
    import pls_pkg::*;

    logic [QW-1:0] cnt_ff  [NQ];
    logic [QW-1:0] nxt_cnt [NQ];
    logic [NQ-1:0] done_ff;
    logic [NQ-1:0] nxt_done;

    // Count while the condition holds, restart from zero when it drops
    always_comb begin
        for (int i = 0; i < NQ; i++) begin
            if (!q.cond[i]) begin
                nxt_cnt[i] = '0;
            end else if (cnt_ff[i] >= q.limit[i]) begin
                nxt_cnt[i] = cnt_ff[i];
            end else begin
                nxt_cnt[i] = cnt_ff[i] + QW'(1);
            end
            nxt_done[i] = q.cond[i] && (nxt_cnt[i] >= q.limit[i]);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < NQ; i++) begin
                cnt_ff[i] <= '0;
            end
            done_ff <= '0;
        end else begin
            for (int i = 0; i < NQ; i++) begin
                cnt_ff[i] <= nxt_cnt[i];
            end
            done_ff <= nxt_done;
        end
    end

    assign q.done = done_ff;

    chk_qual_drop_clears: assert property (
        @(posedge clk) disable iff (!rstn)
        (q.done & ~$past(q.cond)) == '0)
        else $error("qualifier done without its condition");
endmodule : pls_qual_bank

// [hdl/pls_top.sv]
// Protection latch sequencer: fault qualification, latch and release
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
// Operation
// - external OTP/OVP flag qualified, then hard latch
// - thermal stop also disables high-voltage start source
// - long low feedback enters off mode, supply off
// - latch pin window; either crossing latches off
// - latch pin spikes shorter than blanking ignored
// - latch pin latch cleared only by brown-out/reset
// - latch pin ignored until ready to start
// - high flag checked at start, low after soft-start
// - bias current doubled during soft-start only
// - thermal trip stops drive at once, supply kept
// - thermal clear allows regular start with soft-start
// - overload timer clears when limit condition drops
// - autorecovery variant restarts soft-trip latches after delay, else latched
module pls_top #(
    parameter int unsigned OFF_CYC_P     = pls_pkg::OFF_CYC,
    parameter int unsigned SSTART_CYC_P  = pls_pkg::SSTART_CYC,
    parameter int unsigned AUTOREC_CYC_P = pls_pkg::AUTOREC_CYC,
    parameter bit          FREQ_100K     = 1'b0,
    parameter bit          AUTOREC_VAR   = 1'b0
) (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RSTN,
    // Comparator flags and PWM input
    input  wire logic                     EXT_FAULT,
    input  wire logic                     LATCH_HI,
    input  wire logic                     LATCH_LO,
    input  wire logic                     THERMAL_TRIP_FLAG,
    input  wire logic                     VCC_LOW,
    input  wire logic                     VCC_HIGH,
    input  wire logic                     SUPPLY_RESET_LEVEL,
    input  wire logic                     SUPPLY_START_LEVEL,
    input  wire logic                     LINE_START_LEVEL,
    input  wire logic                     BROWNOUT,
    input  wire logic                     FB_OFF,
    input  wire logic                     FB_ON,
    input  wire logic                     CS_LIMIT,
    input  wire logic                     MAX_TON,
    input  wire logic                     CS_STOP,
    input  wire logic                     PWM_IN,
    // Power stage controls
    output logic                          GATE_DRIVE_OUT,
    output logic                          HV_SOURCE_EN,
    output logic                          VCC_INT_EN,
    output logic                          BOOSTED_BIAS_CURRENT,
    // Avalon-MM slave
    input  wire logic [pls_pkg::AW-1:0]   AVS_ADDRESS,
    input  wire logic                     AVS_READ,
    input  wire logic                     AVS_WRITE,
    input  wire logic [31:0]              AVS_WRITEDATA,
    input  wire logic [3:0]               AVS_BYTEENABLE,
    output logic [31:0]                   AVS_READDATA,
    output logic                          AVS_WAITREQUEST,
    // Interrupt
    output logic                          IRQ
);
    import pls_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    pls_state_e    state_ff;
    pls_state_e    nxt_state;
    logic          auto_ff;
    logic          nxt_auto;
    logic          gate_ff;
    logic          nxt_gate;
    logic          hv_ff;
    logic          vint_ff;
    logic          boost_ff;
    logic [31:0]   ctrl_ff;
    logic [31:0]   nxt_ctrl;
    logic [31:0]   mask_ff;
    logic [31:0]   nxt_mask;
    logic [NEV-1:0] stat_ff;
    logic [NEV-1:0] nxt_stat;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] clr;
    logic          irq_ff;
    logic          wait_ff;
    logic          nxt_wait;
    logic [31:0]   rdata_ff;
    logic [31:0]   nxt_rdata;
    logic [31:0]   rd_val;
    logic          run_like;
    logic          release_c;
    logic          start_ok;
    logic          hard_trip;
    logic          soft_trip;
    logic          wr_go;

    // ------------------------------------------------------------------
    // Qualification timers
    // ------------------------------------------------------------------
    pls_qual_if qi ();

    pls_qual_bank u_qual (
        .clk  (CLK),
        .rstn (RSTN),
        .q    (qi.bank)
    );

    assign run_like  = (state_ff == ST_SSTART) || (state_ff == ST_RUN);
    assign release_c = BROWNOUT || SUPPLY_RESET_LEVEL;
    assign start_ok  = LINE_START_LEVEL && SUPPLY_START_LEVEL;

    always_comb begin
        qi.cond         = '0;
        qi.cond[Q_EXT]  = EXT_FAULT && run_like;
        qi.cond[Q_LHI]  = LATCH_HI && run_like;
        qi.cond[Q_LLO]  = LATCH_LO && (state_ff == ST_RUN);
        qi.cond[Q_VLO]  = VCC_LOW && run_like;
        qi.cond[Q_VHI]  = VCC_HIGH && run_like;
        qi.cond[Q_THRM] = THERMAL_TRIP_FLAG && (state_ff != ST_THERM);
        qi.cond[Q_OFFM] = FB_OFF && run_like;
        qi.cond[Q_OVL]  = (CS_LIMIT || MAX_TON) && run_like;
        qi.cond[Q_SS]   = (state_ff == ST_SSTART);
        qi.cond[Q_AR]   = (state_ff == ST_LATCH) && auto_ff;
        qi.limit[Q_EXT]  = FREQ_100K ? QW'(EXT100_CYC) : QW'(EXT65_CYC);
        qi.limit[Q_LHI]  = QW'(LHI_CYC);
        qi.limit[Q_LLO]  = QW'(LLO_CYC);
        qi.limit[Q_VLO]  = QW'(VCC_CYC);
        qi.limit[Q_VHI]  = QW'(VCC_CYC);
        qi.limit[Q_THRM] = QW'(THERM_CYC);
        qi.limit[Q_OFFM] = QW'(OFF_CYC_P);
        qi.limit[Q_OVL]  = QW'(FAULT_CYC);
        qi.limit[Q_SS]   = QW'(SSTART_CYC_P);
        qi.limit[Q_AR]   = QW'(AUTOREC_CYC_P);
    end

    assign hard_trip = qi.done[Q_EXT] || qi.done[Q_LHI] ||
                       qi.done[Q_LLO] || qi.done[Q_VHI];
    assign soft_trip = qi.done[Q_VLO] || qi.done[Q_OVL] ||
                       (CS_STOP && run_like);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_auto  = auto_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_ok && ctrl_ff[CTRL_EN] && !THERMAL_TRIP_FLAG &&
                    !LATCH_HI) begin
                    nxt_state = ST_SSTART;
                end
            end
            ST_SSTART, ST_RUN: begin
                if (release_c) begin
                    nxt_state = ST_IDLE;
                end else if (qi.done[Q_THRM]) begin
                    nxt_state = ST_THERM;
                end else if (hard_trip) begin
                    nxt_state = ST_LATCH;
                    nxt_auto  = 1'b0;
                end else if (soft_trip) begin
                    nxt_state = ST_LATCH;
                    nxt_auto  = 1'b1;
                end else if (qi.done[Q_OFFM]) begin
                    nxt_state = ST_SLEEP;
                end else if (state_ff == ST_SSTART && qi.done[Q_SS]) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_LATCH: begin
                if (release_c) begin
                    nxt_state = ST_IDLE;
                    nxt_auto  = 1'b0;
                end else if (AUTOREC_VAR && auto_ff && qi.done[Q_AR]) begin
                    nxt_state = ST_IDLE;
                    nxt_auto  = 1'b0;
                end
            end
            ST_THERM: begin
                if (SUPPLY_RESET_LEVEL || !THERMAL_TRIP_FLAG) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SLEEP: begin
                if (start_ok && FB_ON) begin
                    nxt_state = ST_SSTART;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_auto  = 1'b0;
            end
        endcase
        nxt_gate = PWM_IN && !THERMAL_TRIP_FLAG && !CS_STOP &&
                   (nxt_state == ST_SSTART || nxt_state == ST_RUN);
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_ff <= ST_IDLE;
            auto_ff  <= 1'b0;
            gate_ff  <= 1'b0;
            hv_ff    <= 1'b1;
            vint_ff  <= 1'b1;
            boost_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            auto_ff  <= nxt_auto;
            gate_ff  <= nxt_gate;
            hv_ff    <= (nxt_state != ST_THERM);
            vint_ff  <= (nxt_state != ST_SLEEP);
            boost_ff <= (nxt_state == ST_SSTART);
        end
    end

    // ------------------------------------------------------------------
    // Register file and Avalon-MM slave
    // ------------------------------------------------------------------
    always_comb begin
        ev         = '0;
        ev[EV_EXT] = qi.done[Q_EXT];
        ev[EV_LHI] = qi.done[Q_LHI];
        ev[EV_LLO] = qi.done[Q_LLO];
        ev[EV_VLO] = qi.done[Q_VLO];
        ev[EV_VHI] = qi.done[Q_VHI];
        ev[EV_THM] = qi.done[Q_THRM];
        ev[EV_OFF] = qi.done[Q_OFFM];
        ev[EV_OVL] = qi.done[Q_OVL];
        ev[EV_SHT] = CS_STOP && run_like;
        ev[EV_BO]  = BROWNOUT;
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (AVS_ADDRESS & 4'hC)
            OFS_CTRL:  rd_val = ctrl_ff;
            OFS_STAT:  rd_val = {{(32-NEV){1'b0}}, stat_ff};
            OFS_MASK:  rd_val = mask_ff;
            OFS_STATE: rd_val = {23'h000000, auto_ff, 2'h0, state_ff};
            default:   rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        wr_go     = AVS_WRITE && !wait_ff;
        nxt_wait  = !((AVS_READ || AVS_WRITE) && wait_ff);
        nxt_rdata = (AVS_READ && wait_ff) ? rd_val : rdata_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_mask  = mask_ff;
        clr       = '0;
        if (wr_go && (AVS_ADDRESS & 4'hC) == OFS_CTRL) begin
            nxt_ctrl = be_merge(ctrl_ff, AVS_WRITEDATA, AVS_BYTEENABLE) &
                       32'h0000_0001;
        end
        if (wr_go && (AVS_ADDRESS & 4'hC) == OFS_MASK) begin
            nxt_mask = be_merge(mask_ff, AVS_WRITEDATA, AVS_BYTEENABLE) &
                       {{(32-NEV){1'b0}}, {NEV{1'b1}}};
        end
        if (wr_go && (AVS_ADDRESS & 4'hC) == OFS_STAT) begin
            clr = NEV'(be_merge(32'h0000_0000, AVS_WRITEDATA,
                                AVS_BYTEENABLE));
        end
        // A new event wins over a simultaneous clear
        nxt_stat = (stat_ff & ~clr) | ev;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ctrl_ff  <= CTRL_RST;
            mask_ff  <= MASK_RST;
            stat_ff  <= '0;
            wait_ff  <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            irq_ff   <= 1'b0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            mask_ff  <= nxt_mask;
            stat_ff  <= nxt_stat;
            wait_ff  <= nxt_wait;
            rdata_ff <= nxt_rdata;
            irq_ff   <= |(nxt_stat & nxt_mask[NEV-1:0]);
        end
    end

    assign GATE_DRIVE_OUT       = gate_ff;
    assign HV_SOURCE_EN         = hv_ff;
    assign VCC_INT_EN           = vint_ff;
    assign BOOSTED_BIAS_CURRENT = boost_ff;
    assign AVS_READDATA         = rdata_ff;
    assign AVS_WAITREQUEST      = wait_ff;
    assign IRQ                  = irq_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_ext_hard_latch: assert property (
        run_like && qi.done[Q_EXT] && !release_c && !qi.done[Q_THRM]
        |=> state_ff == ST_LATCH && !auto_ff)
        else $error("external fault did not hard latch");
    chk_hard_latch_hold: assert property (
        state_ff == ST_LATCH && !auto_ff && !release_c
        |=> state_ff == ST_LATCH)
        else $error("hard latch released without brown-out or reset");
    chk_therm_hv_off: assert property (
        state_ff == ST_THERM |-> !HV_SOURCE_EN && VCC_INT_EN)
        else $error("start source active in thermal stop");
    chk_sleep_supply: assert property (
        state_ff == ST_SLEEP && !(start_ok && FB_ON)
        |-> !VCC_INT_EN ##1 state_ff == ST_SLEEP)
        else $error("off mode left or supply kept on");
    chk_start_high_gate: assert property (
        state_ff == ST_IDLE && LATCH_HI |=> state_ff != ST_SSTART)
        else $error("start while high latch flag set");
    chk_low_ignored_ss: assert property (
        state_ff != ST_RUN |-> !qi.cond[Q_LLO])
        else $error("low latch flag watched before run");
    chk_boost_ss: assert property (
        BOOSTED_BIAS_CURRENT == (state_ff == ST_SSTART))
        else $error("boosted bias outside soft-start");
    chk_therm_drive_off: assert property (
        THERMAL_TRIP_FLAG |=> !GATE_DRIVE_OUT)
        else $error("drive active during thermal trip");
    chk_therm_exit: assert property (
        state_ff == ST_THERM && !THERMAL_TRIP_FLAG
        |=> state_ff == ST_IDLE)
        else $error("thermal stop not left after flag cleared");
    chk_short_latch: assert property (
        run_like && CS_STOP && !release_c && !qi.done[Q_THRM] &&
        !hard_trip |=> state_ff == ST_LATCH && auto_ff)
        else $error("winding short did not latch at once");
    chk_latched_variant: assert property (
        !AUTOREC_VAR && state_ff == ST_LATCH && !release_c
        |=> state_ff == ST_LATCH)
        else $error("latched variant left latch");
    chk_vhi_hard: assert property (
        run_like && qi.done[Q_VHI] && !release_c && !qi.done[Q_THRM]
        |=> state_ff == ST_LATCH && !auto_ff)
        else $error("high supply did not hard latch");

    cov_run: cover property (state_ff == ST_SSTART ##1 state_ff == ST_RUN);
    cov_latch: cover property (run_like ##1 state_ff == ST_LATCH);
    cov_therm: cover property (state_ff == ST_THERM ##1 state_ff == ST_IDLE);
    cov_sleep: cover property (state_ff == ST_SLEEP ##1 state_ff == ST_SSTART);
endmodule : pls_top

// [dv/pls_supply_model.sv]
// Behavioural model of the line, the supply rail and their comparators
`timescale 1ns/10ps
module pls_supply_model (
    // Clock
    input  wire logic CLK,
    // Stimulus and start-up source
    input  wire logic plugged,
    input  wire logic hv_en,
    // Comparator flags
    output logic      line_ok,
    output logic      vcc_start,
    output logic      vcc_reset
);
    logic [3:0] chg_ff;
    // Rail charges only while plugged in and the start-up source is on
    always_ff @(posedge CLK) begin
        if (!plugged) begin
            chg_ff <= 4'h0;
        end else if (hv_en && chg_ff != 4'hF) begin
            chg_ff <= chg_ff + 4'h1;
        end
    end
    assign line_ok   = plugged;
    assign vcc_start = (chg_ff == 4'hF);
    assign vcc_reset = !plugged;
endmodule : pls_supply_model

// [dv/tb_protection_latch_sequencer.sv]
// Self-checking bench for the protection latch sequencer
`timescale 1ns/10ps
module tb_protection_latch_sequencer;
    import pls_pkg::*;
    logic        clk, rstn, plugged, ext, lhi, llo, thm, bo, cs_stop, pwm;
    logic        rd, wr, gate, hv, vint, boost, wreq, irq, line, vst, vrst;
    logic [5:0]  quiet;
    logic [3:0]  addr;
    logic [31:0] wdat, rdat, got;
    int          mismatches, compares, cycles;
    pls_supply_model u_pls_supply_model (.CLK(clk), .plugged(plugged),
        .hv_en(hv), .line_ok(line), .vcc_start(vst), .vcc_reset(vrst));
    pls_top #(.OFF_CYC_P(200), .SSTART_CYC_P(50), .AUTOREC_CYC_P(80))
    u_pls_top (.CLK(clk), .RSTN(rstn), .EXT_FAULT(ext), .LATCH_HI(lhi),
        .LATCH_LO(llo), .THERMAL_TRIP_FLAG(thm), .VCC_LOW(quiet[0]),
        .VCC_HIGH(quiet[1]), .SUPPLY_RESET_LEVEL(vrst),
        .SUPPLY_START_LEVEL(vst), .LINE_START_LEVEL(line), .BROWNOUT(bo),
        .FB_OFF(quiet[2]), .FB_ON(quiet[3]), .CS_LIMIT(quiet[4]),
        .MAX_TON(quiet[5]), .CS_STOP(cs_stop), .PWM_IN(pwm),
        .GATE_DRIVE_OUT(gate), .HV_SOURCE_EN(hv), .VCC_INT_EN(vint),
        .BOOSTED_BIAS_CURRENT(boost), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq), .IRQ(irq));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // One Avalon access; read data lands in got
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic st(input logic [5:0] e, input string m);
        bus(1'b0, OFS_STATE, 32'h0);
        chk(got & 32'h3F, {26'h0, e}, m);
    endtask : st
    task automatic t_reset();
        chk({gate, hv, vint, boost, irq}, 32'h0C, "reset outputs");
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(got, CTRL_RST, "ctrl reset");
        bus(1'b0, OFS_MASK, 32'h0);
        chk(got, MASK_RST, "mask reset");
        st(ST_IDLE, "idle");
    endtask : t_reset
    task automatic t_start();
        repeat (300) if (boost !== 1'b1) @(posedge clk);
        chk(boost, 1, "boost on");
        st(ST_SSTART, "soft start");
        repeat (300) if (boost !== 1'b0) @(posedge clk);
        st(ST_RUN, "run");
        repeat (3) @(posedge clk);
        chk(gate, 1, "gate runs");
    endtask : t_start
    task automatic t_release();
        @(posedge clk);
        bo <= 1'b1;
        repeat (2) @(posedge clk);
        bo <= 1'b0;
        t_start();
    endtask : t_release
    task automatic t_short();
        bus(1'b1, OFS_MASK, 32'h1 << EV_SHT);
        cs_stop <= 1'b1;
        repeat (2) @(posedge clk);
        cs_stop <= 1'b0;
        @(negedge clk);
        chk(gate, 0, "short stop");
        repeat (100) @(posedge clk);
        st(ST_LATCH, "stays latched");
        chk(got[STATE_AUTO], 1, "short latch autorecoverable");
        bus(1'b0, OFS_STAT, 32'h0);
        chk(got[EV_SHT], 1, "short event");
        chk(irq, 1, "irq set");
        bus(1'b1, OFS_STAT, 32'h1 << EV_SHT);
        repeat (2) @(posedge clk);
        chk(irq, 0, "irq clear");
        t_release();
    endtask : t_short
    task automatic t_latch();
        lhi <= 1'b1;
        repeat (400) @(posedge clk);
        lhi <= 1'b0;
        repeat (5) @(posedge clk);
        chk(gate, 1, "spike ignored");
        lhi <= 1'b1;
        repeat (510) @(posedge clk);
        lhi <= 1'b0;
        chk(gate, 0, "window latch");
        repeat (100) @(posedge clk);
        st(ST_LATCH, "latch held");
        t_release();
        llo <= 1'b1;
        repeat (3490) @(posedge clk);
        chk(gate, 1, "low blanking");
        repeat (20) @(posedge clk);
        llo <= 1'b0;
        chk(gate, 0, "low window latch");
        st(ST_LATCH, "low latch held");
        t_release();
    endtask : t_latch
    task automatic t_therm();
        thm <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(gate, 0, "thermal stop");
        repeat (110) @(posedge clk);
        chk({hv, vint}, 1, "hv off, supply kept");
        st(ST_THERM, "thermal");
        thm <= 1'b0;
        t_start();
    endtask : t_therm
    task automatic t_sleep();
        quiet[2] <= 1'b1;
        repeat (210) @(posedge clk);
        chk(vint, 0, "supply off");
        st(ST_SLEEP, "off mode");
        quiet <= 6'h08;
        t_start();
        quiet <= 6'h00;
    endtask : t_sleep
    task automatic t_ext();
        ext <= 1'b1;
        repeat (540) @(posedge clk);
        chk(gate, 1, "ext still qualifying");
        repeat (20) @(posedge clk);
        ext <= 1'b0;
        chk(gate, 0, "ext latched");
        st(ST_LATCH, "ext latch");
        chk(got[STATE_AUTO], 0, "ext latch is hard");
        t_release();
    endtask : t_ext
    initial begin
        {rstn, plugged, ext, lhi, llo, thm, bo, cs_stop, pwm} = '0;
        {rd, wr, quiet, addr, wdat} = '0;
        mismatches = 0;
        compares = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        plugged <= 1'b1;
        pwm <= 1'b1;
        t_start();
        t_short();
        t_latch();
        t_therm();
        t_sleep();
        t_ext();
        end_of_test();
    end
endmodule : tb_protection_latch_sequencer
